// [hw/serial_irq_stream_control.sv]
// Serial interrupt stream control: registers, frame engine and slot status
//
// Operation
// [RULE1] Start width code gives 4, 6, 8 clocks
// [RULE2] Poll bit: 0 continuous, 1 quiet
// [RULE3] Recovery: drive high, or release if set
// [RULE4] Mode bits 7:4 always read zero
// [RULE5] One trigger bit per slot, 1 level
// [RULE6] Level slot assertion sets its status bit
// [RULE7] Writing 1 clears status, re-arming slot
// [RULE8] Edge slots never set status bits
// [RULE9] All fields clear on any reset source
// [RULE10] Memory and config offsets share storage
// [RULE11] Slot n maps to bit n
`timescale 1ns/1ps
`default_nettype none
module serial_irq_stream_control
  import sirq_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic link_fundamental_reset_n_i,
  input wire logic global_reset_input_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_cfg_space_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [1:0] reg_be_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic sirq_clk_i,
  input wire logic serial_interrupt_line_i,
  output logic serial_interrupt_line_o,
  output logic serial_interrupt_line_oe_o
);
  // Elaboration check: status and trigger are 16-bit registers
  initial begin
    if (SLOTS != NUM_SLOTS) begin
      $error("serial_irq_stream_control: SLOTS must be 16");
    end
  end

  // ---------------- Register domain (mclk_i) ----------------
  logic [7:0] mode_ctrl; // Stored mode bits, upper nibble unused
  logic [15:0] slot_trigger_select; // 1 = level handling per slot
  logic [15:0] slot_level_flag; // Sticky level status
  logic [1:0] rst_pins_s; // Synchronised reset pins
  logic soft_clear; // Either reset pin asserted
  logic [15:0] tgl_s; // Slot toggles after crossing
  logic [15:0] tgl_d; // Previous toggles for edge find
  logic [15:0] slot_evt; // One-cycle slot assertion events
  logic hit_mode; // Decoded mode control access
  logic hit_trig; // Decoded trigger select access
  logic hit_stat; // Decoded status access
  logic [15:0] wmask; // Byte lane mask of a write
  logic [15:0] stat_clr; // Write-one-to-clear bits
  logic [15:0] next_rdata; // Read data before register
  logic [15:0] link_tgl; // One toggle per slot, driven in the link domain

  // Reset pins come from outside: two flops first
  sync_2ff #(.WIDTH(2)) u_rst_sync (
    .clk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i({link_fundamental_reset_n_i, global_reset_input_n_i}),
    .sync_o(rst_pins_s)
  );
  // Flops reset to 0, so an idle pin must first be seen high
  assign soft_clear = ~rst_pins_s[1] | ~rst_pins_s[0];

  // Both address paths hit one register set
  assign hit_mode = reg_cfg_space_i ? (reg_addr_i == CFG_MODE_OFS) : (reg_addr_i == MEM_MODE_OFS); // [RULE10]
  assign hit_trig = reg_cfg_space_i ? (reg_addr_i == CFG_TRIG_OFS) : (reg_addr_i == MEM_TRIG_OFS); // [RULE10]
  assign hit_stat = reg_cfg_space_i ? (reg_addr_i == CFG_STAT_OFS) : (reg_addr_i == MEM_STAT_OFS); // [RULE10]
  // Low lane is the even offset, high lane the odd one
  assign wmask = {{8{reg_be_i[1]}}, {8{reg_be_i[0]}}};
  assign stat_clr = (reg_wr_i && hit_stat) ? (reg_wdata_i & wmask) : 16'h0000;

  // Mode control register, only the used nibble is kept
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_ctrl <= MODE_RESET; // [RULE9]
    end else if (soft_clear) begin
      mode_ctrl <= MODE_RESET; // [RULE9]
    end else if (reg_wr_i && hit_mode && reg_be_i[0]) begin
      mode_ctrl <= reg_wdata_i[7:0] & MODE_USED_MASK; // [RULE4]
    end
  end

  // Trigger select register, byte lanes honoured
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_trigger_select <= TRIG_RESET; // [RULE9]
    end else if (soft_clear) begin
      slot_trigger_select <= TRIG_RESET; // [RULE9]
    end else if (reg_wr_i && hit_trig) begin
      slot_trigger_select <= (slot_trigger_select & ~wmask) | (reg_wdata_i & wmask); // [RULE5]
    end
  end

  // Slot events cross as toggles; one flop more finds the change
  sync_2ff #(.WIDTH(16)) u_evt_sync (
    .clk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(link_tgl),
    .sync_o(tgl_s)
  );

  // Previous toggle value
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgl_d <= 16'h0000;
    end else begin
      tgl_d <= tgl_s;
    end
  end
  assign slot_evt = tgl_s ^ tgl_d; // [RULE11]

  // Status: level slots set, writes of one clear; set wins
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_level_flag <= STAT_RESET; // [RULE9]
    end else if (soft_clear) begin
      slot_level_flag <= STAT_RESET; // [RULE9]
    end else begin
      slot_level_flag <= (slot_level_flag & ~stat_clr) | (slot_evt & slot_trigger_select); // [RULE6] [RULE7] [RULE8]
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (hit_mode) begin
      next_rdata = {8'h00, mode_ctrl & MODE_USED_MASK}; // [RULE4]
    end else if (hit_trig) begin
      next_rdata = slot_trigger_select;
    end else if (hit_stat) begin
      next_rdata = slot_level_flag;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 16'h0000;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ---------------- Link domain (sirq_clk_i) ----------------
  logic [3:0] mode_link; // Mode bits seen by the link
  link_state_t state; // Frame state
  link_state_t next_state; // Frame state, next
  logic [3:0] cnt; // Clocks spent in a long phase
  logic [3:0] next_cnt; // Counter, next
  logic [3:0] slot; // Current slot number
  logic [3:0] next_slot; // Slot, next
  logic [3:0] frame_len; // Start width latched per frame
  logic [3:0] stop_len; // Stop width for current poll mode
  logic [3:0] mode_link_d; // Previous mode sample; width latched only when two agree
  logic [3:0] low_run; // Helper: clocks driven low in a row

  // Mode bits are quasi-static levels; width is latched per frame
  sync_2ff #(.WIDTH(4)) u_mode_sync (
    .clk_i(sirq_clk_i),
    .nrst_i(nrst_i),
    .async_i(mode_ctrl[3:0]),
    .sync_o(mode_link)
  );

  // Start width from the code; reserved code falls back to 4
  function automatic logic [3:0] width_of(input logic [1:0] code);
    case (code)
      WIDTH_CODE_6: width_of = START_CLKS_6; // [RULE1]
      WIDTH_CODE_8: width_of = START_CLKS_8; // [RULE1]
      default: width_of = START_CLKS_4; // [RULE1]
    endcase
  endfunction

  // Quiet frames end with the shorter stop pulse
  assign stop_len = mode_link[MODE_POLL_BIT] ? STOP_CLKS_QUIET : STOP_CLKS_CONT;

  // Frame sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt + 4'h1;
    next_slot = slot;
    case (state)
      LS_IDLE: begin
        next_cnt = 4'h0;
        // Continuous starts at once; quiet waits for a peripheral low
        if (!mode_link[MODE_POLL_BIT] || !serial_interrupt_line_i) begin // [RULE2]
          next_state = LS_START;
        end
      end
      LS_START: begin
        if (cnt == frame_len - 4'h1) begin // [RULE1]
          next_state = LS_START_REC;
        end
      end
      LS_START_REC: next_state = LS_START_TA;
      LS_START_TA: begin
        next_state = LS_SLOT_SAMPLE;
        next_slot = 4'h0;
      end
      LS_SLOT_SAMPLE: next_state = LS_SLOT_REC;
      LS_SLOT_REC: next_state = LS_SLOT_TA;
      LS_SLOT_TA: begin
        next_cnt = 4'h0;
        if (slot == 4'hF) begin
          next_state = LS_STOP;
        end else begin
          next_state = LS_SLOT_SAMPLE;
          next_slot = slot + 4'h1;
        end
      end
      LS_STOP: begin
        if (cnt == stop_len - 4'h1) begin
          next_state = LS_STOP_REC;
        end
      end
      LS_STOP_REC: next_state = LS_STOP_TA;
      LS_STOP_TA: next_state = LS_IDLE;
      default: next_state = LS_IDLE;
    endcase
  end

  // State, counters and frame width
  always_ff @(posedge sirq_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= LS_IDLE;
      cnt <= 4'h0;
      slot <= 4'h0;
      frame_len <= START_CLKS_4;
      mode_link_d <= 4'h0;
    end else begin
      state <= next_state;
      cnt <= (next_state == state) ? next_cnt : 4'h0;
      slot <= next_slot;
      mode_link_d <= mode_link;
      if (state == LS_IDLE && mode_link == mode_link_d) begin
        frame_len <= width_of(mode_link[MODE_WIDTH_LSB +: 2]); // [RULE1]
      end
    end
  end

  // Line drive follows the next state so pins line up with state
  always_ff @(posedge sirq_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_interrupt_line_o <= 1'b1;
      serial_interrupt_line_oe_o <= 1'b0;
    end else begin
      case (next_state)
        LS_START, LS_STOP: begin
          serial_interrupt_line_o <= 1'b0;
          serial_interrupt_line_oe_o <= 1'b1;
        end
        LS_START_REC, LS_SLOT_REC, LS_STOP_REC: begin
          // Release instead when the recovery drive bit is set
          serial_interrupt_line_o <= 1'b1;
          serial_interrupt_line_oe_o <= ~mode_link[MODE_DRIVE_BIT]; // [RULE3]
        end
        default: begin
          serial_interrupt_line_o <= 1'b1;
          serial_interrupt_line_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Low in a sample phase flips that slot's toggle
  always_ff @(posedge sirq_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_tgl <= 16'h0000;
    end else if (state == LS_SLOT_SAMPLE && !serial_interrupt_line_i) begin
      link_tgl[slot] <= ~link_tgl[slot]; // [RULE11]
    end
  end

  // Helper for checks: length of our own low drive
  always_ff @(posedge sirq_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_run <= 4'h0;
    end else if (serial_interrupt_line_oe_o && !serial_interrupt_line_o) begin
      low_run <= (low_run == 4'hF) ? low_run : low_run + 4'h1;
    end else begin
      low_run <= 4'h0;
    end
  end

  // ---------------- Checks ----------------
  start_width_a: assert property ( // [RULE1]
    @(posedge sirq_clk_i) disable iff (!nrst_i)
    (state == LS_START_REC && $past(state) == LS_START) |-> low_run == frame_len)
    else $error("start frame low time wrong");

  width_latch_a: assert property ( // [RULE1]
    @(posedge sirq_clk_i) disable iff (!nrst_i)
    (state == LS_IDLE && mode_link == mode_link_d && mode_link[3:2] == WIDTH_CODE_8) |=> frame_len == START_CLKS_8)
    else $error("start width not latched from code");

  poll_mode_a: assert property ( // [RULE2]
    @(posedge sirq_clk_i) disable iff (!nrst_i)
    (state == LS_IDLE) |=> (state == LS_START) == $past(!mode_link[MODE_POLL_BIT] || !serial_interrupt_line_i))
    else $error("frame start disagrees with poll mode");

  recovery_drive_a: assert property ( // [RULE3]
    @(posedge sirq_clk_i) disable iff (!nrst_i)
    (state == LS_SLOT_REC) |-> serial_interrupt_line_oe_o == $past(~mode_link[MODE_DRIVE_BIT]) && serial_interrupt_line_o)
    else $error("recovery drive wrong");

  reserved_zero_a: assert property ( // [RULE4]
    @(posedge mclk_i) disable iff (!nrst_i)
    (reg_rd_i && hit_mode) |=> reg_rvalid_o && reg_rdata_o[15:4] == 12'h000)
    else $error("mode reserved bits not zero");

  level_set_a: assert property ( // [RULE6]
    @(posedge mclk_i) disable iff (!nrst_i || soft_clear)
    ((slot_evt & slot_trigger_select) != 16'h0000) |=> (slot_level_flag & $past(slot_evt & slot_trigger_select))
      == $past(slot_evt & slot_trigger_select))
    else $error("level slot did not set status");

  w1c_clear_a: assert property ( // [RULE7]
    @(posedge mclk_i) disable iff (!nrst_i)
    (stat_clr != 16'h0000 && slot_evt == 16'h0000) |=> (slot_level_flag & $past(stat_clr)) == 16'h0000)
    else $error("status not cleared by write of one");

  edge_never_a: assert property ( // [RULE8]
    @(posedge mclk_i) disable iff (!nrst_i)
    ##1 (slot_level_flag & ~$past(slot_level_flag) & ~$past(slot_trigger_select)) == 16'h0000)
    else $error("edge slot set a status bit");

  pin_clear_a: assert property ( // [RULE9]
    @(posedge mclk_i) disable iff (!nrst_i)
    soft_clear |=> mode_ctrl == MODE_RESET && slot_trigger_select == TRIG_RESET && slot_level_flag == STAT_RESET)
    else $error("fields not cleared by reset pin");

  alias_read_a: assert property ( // [RULE10]
    @(posedge mclk_i) disable iff (!nrst_i)
    (reg_rd_i && hit_trig) |=> reg_rdata_o == $past(slot_trigger_select))
    else $error("trigger select read mismatch");

  slot_map_a: assert property ( // [RULE11]
    @(posedge sirq_clk_i) disable iff (!nrst_i)
    (state == LS_SLOT_SAMPLE && !serial_interrupt_line_i) |=> link_tgl[$past(slot)] != $past(link_tgl[slot]))
    else $error("slot event landed on wrong bit");

  level_seen_c: cover property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (slot_evt & slot_trigger_select) != 16'h0000);

  quiet_start_c: cover property (
    @(posedge sirq_clk_i) disable iff (!nrst_i)
    state == LS_IDLE && mode_link[MODE_POLL_BIT] ##1 state == LS_START);

  rearm_c: cover property (
    @(posedge mclk_i) disable iff (!nrst_i)
    (stat_clr & slot_level_flag) != 16'h0000);

  wide_start_c: cover property (
    @(posedge sirq_clk_i) disable iff (!nrst_i)
    state == LS_START_REC && low_run == START_CLKS_8);
endmodule // serial_irq_stream_control
`default_nettype wire

// [hw/sirq_pkg.sv]
// Constants and types shared by the serial interrupt stream control block
package sirq_pkg;
  // Register offsets, memory window
  localparam logic [7:0] MEM_MODE_OFS = 8'h48;
  localparam logic [7:0] MEM_TRIG_OFS = 8'h4A;
  localparam logic [7:0] MEM_STAT_OFS = 8'h4C;
  // Register offsets, configuration space alias
  localparam logic [7:0] CFG_MODE_OFS = 8'hE0;
  localparam logic [7:0] CFG_TRIG_OFS = 8'hE2;
  localparam logic [7:0] CFG_STAT_OFS = 8'hE4;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] TRIG_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  // Mode control fields
  localparam logic [7:0] MODE_USED_MASK = 8'h0F;
  localparam int MODE_DRIVE_BIT = 0;
  localparam int MODE_POLL_BIT = 1;
  localparam int MODE_WIDTH_LSB = 2;
  // Start width codes
  localparam logic [1:0] WIDTH_CODE_6 = 2'h1;
  localparam logic [1:0] WIDTH_CODE_8 = 2'h2;
  // Frame timing in link clocks
  localparam logic [3:0] START_CLKS_4 = 4'h4;
  localparam logic [3:0] START_CLKS_6 = 4'h6;
  localparam logic [3:0] START_CLKS_8 = 4'h8;
  localparam logic [3:0] STOP_CLKS_QUIET = 4'h2;
  localparam logic [3:0] STOP_CLKS_CONT = 4'h3;
  localparam int NUM_SLOTS = 16;
  // Link frame states
  typedef enum logic [3:0] {
    LS_IDLE, LS_START, LS_START_REC, LS_START_TA,
    LS_SLOT_SAMPLE, LS_SLOT_REC, LS_SLOT_TA,
    LS_STOP, LS_STOP_REC, LS_STOP_TA
  } link_state_t;
endpackage

// [hw/sync_2ff.sv]
// Two flip-flop synchroniser for a group of level signals
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) begin
      $error("sync_2ff: WIDTH must be at least 1");
    end
  end

  // Both stages clear to zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sync_2ff
`default_nettype wire

// [test/sirq_peer_model.sv]
// Peripheral group sharing the serial interrupt line, with frame tracking
`timescale 1ns/1ps
`default_nettype none
module sirq_peer_model (
  input wire logic sirq_clk_i,
  input wire logic nrst_i,
  input wire logic line_oe_i,
  input wire logic line_o_i,
  input wire logic [15:0] slot_req_i,
  input wire logic start_req_i,
  output logic peer_low_o,
  output logic [15:0] frames_o,
  output logic [7:0] last_run_o,
  output logic rec_oe_o
);
  logic host_low; // Controller pulling the line low
  logic [7:0] run; // Length of the current low run
  int cnt; // Cycles since the start recovery cycle
  int nc; // Next value of cnt
  assign host_low = line_oe_i && !line_o_i;
  // Stop pulses are 2 or 3 long, so only runs of 4+ mark a start frame
  always @(posedge sirq_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run <= 8'h00;
      cnt <= 1000;
      frames_o <= 16'h0000;
      last_run_o <= 8'h00;
      rec_oe_o <= 1'b0;
      peer_low_o <= 1'b0;
    end else begin
      nc = (!host_low && run >= 8'h04) ? 0 : cnt + 1;
      cnt <= nc;
      run <= host_low ? run + 8'h01 : 8'h00;
      // End of start: record width and recovery drive
      if (!host_low && run >= 8'h04) begin
        frames_o <= frames_o + 16'h0001;
        last_run_o <= run;
        rec_oe_o <= line_oe_i;
      end
      // Slot n sample cycle lies 1+3n after turnaround; pull low there
      peer_low_o <= start_req_i || (nc >= 1 && nc <= 46 && (nc - 1) % 3 == 0 && slot_req_i[(nc - 1) / 3]);
    end
  end
endmodule // sirq_peer_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the serial interrupt stream control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sirq_pkg::*;
  logic mclk, nrst, sirq_clk; // Clocks and power-on reset
  logic [1:0] rst_pins_n; // Bit 0 link reset, bit 1 global reset
  logic reg_wr, reg_rd, reg_cfg, reg_rvalid, line_o, line_oe, peer_low, rec_oe, start_req;
  logic [7:0] reg_addr, last_run;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata, reg_rdata, slot_req, frames;
  wire sirq_wire; // Pull-up when nobody drives low
  int failures, checked, m_mode, m_trig, m_stat, f; // Counters and register model
  int widths[4] = '{4, 6, 8, 4}; // Start width per code; reserved code runs as 4
  logic [31:0] t, r;
  assign sirq_wire = line_oe ? line_o : ~peer_low;
  serial_irq_stream_control i_dut (
    .mclk_i(mclk), .nrst_i(nrst), .link_fundamental_reset_n_i(rst_pins_n[0]),
    .global_reset_input_n_i(rst_pins_n[1]), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_cfg_space_i(reg_cfg), .reg_addr_i(reg_addr), .reg_be_i(reg_be), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .sirq_clk_i(sirq_clk),
    .serial_interrupt_line_i(sirq_wire), .serial_interrupt_line_o(line_o),
    .serial_interrupt_line_oe_o(line_oe));
  sirq_peer_model i_peer (
    .sirq_clk_i(sirq_clk), .nrst_i(nrst), .line_oe_i(line_oe), .line_o_i(line_o),
    .slot_req_i(slot_req), .start_req_i(start_req), .peer_low_o(peer_low),
    .frames_o(frames), .last_run_o(last_run), .rec_oe_o(rec_oe));
  // Register clock, 10 ns
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Link clock, 48 ns; 2.5 ns phase keeps its edges off every mclk edge
  initial begin
    sirq_clk = 1'b0;
    #2.5;
    forever #24 sirq_clk = ~sirq_clk;
  end
  // Verdict and end of run
  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One register write; strobe lasts one cycle
  task automatic wr(input logic cfg, input logic [7:0] ofs, input logic [1:0] be, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_cfg <= cfg;
    reg_addr <= ofs;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // One register read, compared on the valid cycle
  task automatic rdc(input logic cfg, input logic [7:0] ofs, input logic [15:0] exp);
    int n;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_cfg <= cfg;
    reg_addr <= ofs;
    @(posedge mclk);
    reg_rd <= 1'b0;
    n = 0;
    @(negedge mclk);
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (n == 4) begin
      failures++;
      conclude();
    end else chk(reg_rdata, exp);
  endtask
  // All three registers through both paths
  task automatic check_regs();
    for (int p = 0; p < 2; p++) begin
      rdc(p[0], p[0] ? CFG_MODE_OFS : MEM_MODE_OFS, 16'(m_mode));
      rdc(p[0], p[0] ? CFG_TRIG_OFS : MEM_TRIG_OFS, 16'(m_trig));
      rdc(p[0], p[0] ? CFG_STAT_OFS : MEM_STAT_OFS, 16'(m_stat));
    end
  endtask
  // Bounded wait for n more start frames
  task automatic wait_frames(input int n);
    int f0;
    int k;
    f0 = frames;
    k = 0;
    while (frames < f0 + n && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    if (k == 20000) begin
      failures++;
      conclude();
    end
  endtask
  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, reg_cfg, start_req} = 5'h00;
    rst_pins_n = 2'h3;
    {reg_addr, reg_be, reg_wdata, slot_req} = 42'h000_0000_0000;
    failures = 0;
    checked = 0;
    m_mode = 0;
    m_trig = 0;
    m_stat = 0;
    void'($urandom(22));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    check_regs();
    rdc(1'b0, 8'h50, 16'h0000);
    wr(1'b0, MEM_MODE_OFS, 2'b01, 16'h00FF);
    wr(1'b1, CFG_MODE_OFS, 2'b10, 16'h0000);
    rdc(1'b1, CFG_MODE_OFS, 16'h000F);
    // Each width code with alternating recovery drive, continuous polling
    for (int c = 0; c < 4; c++) begin
      m_mode = c * 4 + (c & 1);
      wr(c[0], c[0] ? CFG_MODE_OFS : MEM_MODE_OFS, 2'b01, 16'(m_mode));
      wait_frames(2);
      chk(16'(last_run), 16'(widths[c]));
      chk(16'(rec_oe), 16'((c & 1) ^ 1));
    end
    // Random trigger modes and slot requests, then write-one clears
    for (int i = 0; i < 3; i++) begin
      t = $urandom();
      r = $urandom();
      m_trig = t[15:0];
      wr(1'b1, CFG_TRIG_OFS, 2'b11, t[15:0]);
      slot_req <= r[15:0];
      wait_frames(2);
      slot_req <= 16'h0000;
      wait_frames(2);
      repeat (10) @(posedge mclk);
      m_stat = m_stat | (m_trig & r[15:0]);
      rdc(1'b0, MEM_STAT_OFS, 16'(m_stat));
      rdc(1'b0, MEM_TRIG_OFS, 16'(m_trig));
      wr(1'b0, MEM_STAT_OFS, 2'b11, t[31:16]);
      m_stat = m_stat & ~int'(t[31:16]);
      rdc(1'b1, CFG_STAT_OFS, 16'(m_stat));
    end
    // Quiet polling: no frame until a peripheral pulls the line low
    m_mode = 2;
    wr(1'b0, MEM_MODE_OFS, 2'b01, 16'h0002);
    repeat (400) @(posedge mclk);
    f = frames;
    repeat (600) @(posedge mclk);
    chk(frames, 16'(f));
    @(posedge sirq_clk);
    start_req <= 1'b1;
    @(posedge sirq_clk);
    start_req <= 1'b0;
    wait_frames(1);
    chk(16'(last_run), 16'h0004);
    // Each reset pin clears every field
    for (int p = 0; p < 2; p++) begin
      wr(1'b0, MEM_TRIG_OFS, 2'b11, 16'hA5C3);
      wr(1'b1, CFG_MODE_OFS, 2'b01, 16'h0009);
      rst_pins_n[p] <= 1'b0;
      repeat (6) @(posedge mclk);
      rst_pins_n[p] <= 1'b1;
      repeat (5) @(posedge mclk);
      m_mode = 0;
      m_trig = 0;
      m_stat = 0;
      check_regs();
    end
    conclude();
  end
endmodule // tb
`default_nettype wire
